//--- hdl/imc_params.svh
`ifndef IMC_PARAMS_SVH
`define IMC_PARAMS_SVH
// register indices; byte address is four times the index
`define IMC_IDX_MODE1    8'h1c
`define IMC_IDX_MODE2    8'h1d
`define IMC_IDX_MODE3    8'h1e
`define IMC_IDX_TW_BASE  8'h30
`define IMC_IDX_TW_LAST  8'h33
`define IMC_IDX_UPDATE   8'h36
`define IMC_IDX_STATUS   8'h3f
// fields of the first-stage register and the update bit
`define IMC_BIT_PREMOD   2
`define IMC_FAC_LSB      4
`define IMC_FAC_X2       2'h0
`define IMC_FAC_X4       2'h1
`define IMC_FAC_X8       2'h2
`define IMC_BIT_UPDATE   0
// reset values
`define IMC_RST_MODE1    8'h20
`define IMC_RST_MODE23   6'h00
`define IMC_RST_TW       32'h0000_0000
// bus encodings and buffer depth
`define IMC_HSIZE_WORD   3'h2
`define IMC_HRESP_OKAY   1'b0
`define IMC_BUF_DEPTH    2'h2
`endif

//--- hdl/imc_pkg.sv
package imc_pkg;
   typedef struct packed {
      logic [15:0] i;
      logic [15:0] q;
   } imc_sample_t;
   typedef struct packed {
      logic [1:0] first_mode;
      logic [2:0] second_mode;
      logic [2:0] third_mode;
      logic       second_en;
      logic       third_en;
      logic       second_mod;
      logic       third_mod;
      logic       premod_en;
   } imc_cfg_t;
   typedef struct packed {
      imc_sample_t sample;
      logic [31:0] phase;
      logic        premod_neg;
      logic [2:0]  tick;
      logic [2:0]  beat;
      imc_cfg_t    cfg;
   } imc_beat_t;
endpackage

//--- hdl/imc_config.sv
`timescale 1ns/1ps
`include "imc_params.svh"
// Summary of operation
// - mode fields sit at indices 0x1c..0x1e: 2-bit first, 6-bit second and third
// - first-stage codes 00..11 pick modes 0..3, shifts 0, fd/2, fd, 1.5fd
// - 4x uses first and second stage; 2x bypasses second and third
// - first mode 1 or 3 with premodulation adds an fd/2 shift
// - each stage runs at twice the rate of the previous one
// - oscillator steps tuning word per tick at twice the data rate
// - later stages have eight modes; modes 4..7 add modulation at input rate
// - new tuning word applies only on a 0-to-1 step of the update bit
module imc_config
(
   input  wire logic                 ref_clk_in,
   input  wire logic                 srst_in,
   input  wire logic                 ce_in,
   input  wire logic                 hsel_in,
   input  wire logic [31:0]          haddr_in,
   input  wire logic [1:0]           htrans_in,
   input  wire logic                 hwrite_in,
   input  wire logic [2:0]           hsize_in,
   input  wire logic                 hready_in,
   input  wire logic [31:0]          hwdata_in,
   output logic      [31:0]          hrdata_out,
   output logic                      hreadyout_out,
   output logic                      hresp_out,
   input  wire logic                 in_valid_in,
   input  wire imc_pkg::imc_sample_t in_sample_in,
   output logic                      in_ready_out,
   output logic                      out_valid_out,
   output imc_pkg::imc_beat_t        out_beat_out,
   input  wire logic                 out_ready_in
);
   logic [7:0]           mode1_q;
   logic [5:0]           mode2_q;
   logic [5:0]           mode3_q;
   logic [31:0]          tw_stage_q;
   logic [31:0]          tw_act_q;
   logic                 upd_q;
   logic                 wr_pend_q;
   logic                 rd_pend_q;
   logic [7:0]           idx_q;
   logic [31:0]          hrdata_q;
   logic                 hready_q;
   imc_pkg::imc_sample_t buf_q [2];
   logic                 wptr_q;
   logic                 rptr_q;
   logic [1:0]           cnt_q;
   logic                 in_ready_q;
   logic                 out_valid_q;
   imc_pkg::imc_beat_t   beat_q;
   logic [31:0]          phase_q;
   logic                 neg_q;

   function automatic logic tick_at(input logic [2:0] b, input logic [1:0] sh);
      logic [2:0] mask;
      mask = 3'((4'h1 << sh) - 4'h1);
      return (b & mask) == 3'h0;
   endfunction

   // bus decode
   wire       acc     = ce_in && hsel_in && htrans_in[1] && hready_in
                        && hsize_in == `IMC_HSIZE_WORD;
   wire [7:0] acc_idx = haddr_in[9:2];
   wire       wr_en   = ce_in && wr_pend_q;
   wire       in_tw   = idx_q >= `IMC_IDX_TW_BASE && idx_q <= `IMC_IDX_TW_LAST;
   wire [1:0] tw_lane = idx_q[1:0];
   wire       upd_set = wr_en && idx_q == `IMC_IDX_UPDATE;
   wire       upd_new = hwdata_in[`IMC_BIT_UPDATE];
   wire       upd_rise = upd_set && !upd_q && upd_new;

   // shadow configuration decode
   wire [1:0]        fac_reg = mode1_q[`IMC_FAC_LSB +: 2];
   imc_pkg::imc_cfg_t cfg_new;
   assign cfg_new.first_mode  = mode1_q[1:0];
   assign cfg_new.second_mode = mode2_q[2:0];
   assign cfg_new.third_mode  = mode3_q[2:0];
   assign cfg_new.second_en   = fac_reg != `IMC_FAC_X2;
   assign cfg_new.third_en    = fac_reg[1];
   assign cfg_new.second_mod  = cfg_new.second_en && mode2_q[2];
   assign cfg_new.third_mod   = cfg_new.third_en && mode3_q[2];
   assign cfg_new.premod_en   = mode1_q[`IMC_BIT_PREMOD] && mode1_q[0];
   wire [1:0] fac_new = {cfg_new.third_en, cfg_new.second_en && !cfg_new.third_en};

   // active word decode
   wire [1:0] fac_cur  = {beat_q.cfg.third_en,
                          beat_q.cfg.second_en && !beat_q.cfg.third_en};
   wire [2:0] last_b   = 3'((4'h2 << fac_cur) - 4'h1);
   wire       adv      = ce_in && (!out_valid_q || out_ready_in);
   wire       more     = out_valid_q && beat_q.beat != last_b;
   wire       pop      = adv && !more && cnt_q != 2'h0;
   wire       push     = ce_in && in_valid_in && in_ready_q;
   wire [1:0] cnt_d    = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
   wire [2:0] nb       = more ? 3'(beat_q.beat + 3'h1) : 3'h0;
   wire [1:0] fac_nb   = more ? fac_cur : fac_new;
   imc_pkg::imc_cfg_t cfg_nb;
   assign cfg_nb = more ? beat_q.cfg : cfg_new;
   wire [2:0] tick_nb  = {cfg_nb.third_en,
                          cfg_nb.second_en && tick_at(nb, fac_nb - 2'h1),
                          tick_at(nb, fac_nb)};
   wire       emit     = adv && (more || pop);
   wire       step     = out_valid_q && adv && beat_q.tick[0];
   wire [31:0] phase_d = step ? phase_q + tw_act_q : phase_q;
   wire       neg_d    = (pop && cfg_new.premod_en) ? !neg_q : neg_q;

   // read mux
   wire [31:0] rd_mux =
      idx_q == `IMC_IDX_MODE1  ? {24'h0, mode1_q} :
      idx_q == `IMC_IDX_MODE2  ? {26'h0, mode2_q} :
      idx_q == `IMC_IDX_MODE3  ? {26'h0, mode3_q} :
      in_tw                    ? {24'h0, tw_stage_q[8*tw_lane +: 8]} :
      idx_q == `IMC_IDX_UPDATE ? {31'h0, upd_q} :
      idx_q == `IMC_IDX_STATUS ? {27'h0, cnt_q, fac_cur, out_valid_q} :
                                 32'h0;

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         idx_q     <= 8'h00;
         hrdata_q  <= 32'h0;
         hready_q  <= 1'b1;
      end
      else if (ce_in)
      begin
         wr_pend_q <= acc && hwrite_in;
         rd_pend_q <= acc && !hwrite_in;
         hready_q  <= !(acc && !hwrite_in);
         if (acc)
            idx_q <= acc_idx;
         if (rd_pend_q)
            hrdata_q <= rd_mux;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         mode1_q    <= `IMC_RST_MODE1;
         mode2_q    <= `IMC_RST_MODE23;
         mode3_q    <= `IMC_RST_MODE23;
         tw_stage_q <= `IMC_RST_TW;
         tw_act_q   <= `IMC_RST_TW;
         upd_q      <= 1'b0;
      end
      else if (wr_en)
      begin
         if (idx_q == `IMC_IDX_MODE1)
            mode1_q <= hwdata_in[7:0];
         if (idx_q == `IMC_IDX_MODE2)
            mode2_q <= hwdata_in[5:0];
         if (idx_q == `IMC_IDX_MODE3)
            mode3_q <= hwdata_in[5:0];
         if (in_tw)
            tw_stage_q[8*tw_lane +: 8] <= hwdata_in[7:0];
         if (upd_set)
            upd_q <= upd_new;
         if (upd_rise)
            tw_act_q <= tw_stage_q;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         wptr_q     <= 1'b0;
         rptr_q     <= 1'b0;
         cnt_q      <= 2'h0;
         in_ready_q <= 1'b0;
      end
      else if (ce_in)
      begin
         if (push)
         begin
            buf_q[wptr_q] <= in_sample_in;
            wptr_q        <= !wptr_q;
         end
         if (pop)
            rptr_q <= !rptr_q;
         cnt_q      <= cnt_d;
         in_ready_q <= cnt_d != `IMC_BUF_DEPTH;
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         out_valid_q <= 1'b0;
         beat_q      <= '0;
         phase_q     <= 32'h0;
         neg_q       <= 1'b0;
      end
      else if (ce_in)
      begin
         phase_q <= phase_d;
         neg_q   <= neg_d;
         if (adv)
            out_valid_q <= emit;
         if (emit)
         begin
            beat_q.beat       <= nb;
            beat_q.cfg        <= cfg_nb;
            beat_q.tick       <= tick_nb;
            beat_q.phase      <= phase_d;
            beat_q.premod_neg <= neg_d;
            if (pop)
               beat_q.sample <= buf_q[rptr_q];
         end
      end
   end

   assign hrdata_out    = hrdata_q;
   assign hreadyout_out = hready_q;
   assign hresp_out     = `IMC_HRESP_OKAY;
   assign in_ready_out  = in_ready_q;
   assign out_valid_out = out_valid_q;
   assign out_beat_out  = beat_q;

   property p_mode1_write;
      @(posedge ref_clk_in) disable iff (srst_in)
      wr_en && idx_q == `IMC_IDX_MODE1 |=> mode1_q[1:0] == $past(hwdata_in[1:0]);
   endproperty
   a_mode1_write: assert property (p_mode1_write) else $error("first mode not stored");

   property p_first_mode;
      @(posedge ref_clk_in) disable iff (srst_in)
      pop |=> beat_q.cfg.first_mode == $past(mode1_q[1:0]);
   endproperty
   a_first_mode: assert property (p_first_mode) else $error("first mode not latched");

   property p_bypass;
      @(posedge ref_clk_in) disable iff (srst_in)
      out_valid_q |-> (beat_q.cfg.third_en |-> beat_q.cfg.second_en);
   endproperty
   a_bypass: assert property (p_bypass) else $error("third stage without second");

   property p_premod;
      @(posedge ref_clk_in) disable iff (srst_in)
      pop && cfg_new.premod_en |=> beat_q.premod_neg != $past(neg_q);
   endproperty
   a_premod: assert property (p_premod) else $error("premodulation sign not toggled");

   property p_rates;
      @(posedge ref_clk_in) disable iff (srst_in)
      out_valid_q && beat_q.tick[0] && beat_q.cfg.second_en |-> beat_q.tick[1];
   endproperty
   a_rates: assert property (p_rates) else $error("stage ticks not nested");

   property p_nco;
      @(posedge ref_clk_in) disable iff (srst_in)
      step |=> phase_q == $past(phase_q) + $past(tw_act_q);
   endproperty
   a_nco: assert property (p_nco) else $error("oscillator step wrong");

   property p_mod;
      @(posedge ref_clk_in) disable iff (srst_in)
      out_valid_q && beat_q.cfg.second_en |->
         beat_q.cfg.second_mod == beat_q.cfg.second_mode[2];
   endproperty
   a_mod: assert property (p_mod) else $error("second stage modulation wrong");

   property p_update;
      @(posedge ref_clk_in) disable iff (srst_in)
      upd_rise |=> tw_act_q == $past(tw_stage_q) ##1 upd_q;
   endproperty
   a_update: assert property (p_update) else $error("tuning word not applied");

   property p_hold;
      @(posedge ref_clk_in) disable iff (srst_in)
      !upd_rise |=> $stable(tw_act_q);
   endproperty
   a_hold: assert property (p_hold) else $error("tuning word changed early");

   property p_cfg;
      @(posedge ref_clk_in) disable iff (srst_in)
      emit && more |=> $stable(beat_q.cfg) && $stable(beat_q.sample);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config changed inside word");

   c_x8: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      emit && beat_q.beat == 3'h7);
   c_update: cover property (@(posedge ref_clk_in) disable iff (srst_in) upd_rise);
   c_full: cover property (@(posedge ref_clk_in) disable iff (srst_in)
      cnt_q == 2'h2 && !out_ready_in);
endmodule

//--- tb/imc_source.sv
`timescale 1ns/1ps
module imc_source
(
   input  wire logic            ref_clk_in,
   input  wire logic            srst_in,
   input  wire logic            in_ready_in,
   output logic                 in_valid_out,
   output imc_pkg::imc_sample_t in_sample_out
);
   imc_pkg::imc_sample_t q[$];
   logic [31:0]          rnd = 32'h5a5a_0f0f;
   // offers queued words with random gaps, holds each until taken
   always @(posedge ref_clk_in)
   begin
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      if (srst_in)
      begin
         in_valid_out  <= 1'b0;
         in_sample_out <= 32'hffff_ffff;
      end
      else if (!in_valid_out || in_ready_in)
      begin
         if (in_valid_out)
            void'(q.pop_front());
         if (q.size() != 0 && rnd[2])
         begin
            in_valid_out <= 1'b1;
            in_sample_out <= q[0];
         end
         else
         begin
            in_valid_out <= 1'b0;
            // released lines keep toggling
            in_sample_out <= ~in_sample_out;
         end
      end
   end
endmodule

//--- tb/interpolation_mode_config_test.sv
`timescale 1ns/1ps
`include "imc_params.svh"
module interpolation_mode_config_test;
   typedef struct {imc_pkg::imc_sample_t s; imc_pkg::imc_cfg_t c; int n; bit chk;
      logic [31:0] step;} imc_note_t;
   logic                 ref_clk_in = 1'b0;
   logic                 srst_in = 1'b1;
   logic                 hsel = 1'b0;
   logic                 hwrite = 1'b0;
   logic [1:0]           htrans = 2'h0;
   logic [31:0]          haddr = 32'h0;
   logic [31:0]          hwdata = 32'h0;
   logic [31:0]          rnd = 32'hc500d8f5;
   logic [31:0]          stall = 32'hc500d8f5;
   logic [31:0]          prevph = 32'h0;
   logic [31:0]          dph;
   logic [2:0]           tk;
   logic                 negexp = 1'b0;
   logic [31:0]          tw = 32'h1999_9999;
   logic [31:0]          hrdata;
   logic                 hready, hresp, in_valid, in_ready, out_valid;
   logic                 out_ready = 1'b0;
   imc_pkg::imc_sample_t in_sample;
   imc_pkg::imc_beat_t   out_beat;
   imc_pkg::imc_cfg_t    c;
   imc_note_t            notes[$];
   imc_note_t            n;
   logic [5:0]           m2, m3;
   int                   num_errors = 0, checks = 0, bcnt = 0, cyc = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   imc_config i_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(1'b1),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(`IMC_HSIZE_WORD), .hready_in(hready), .hwdata_in(hwdata),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .in_valid_in(in_valid), .in_sample_in(in_sample), .in_ready_out(in_ready),
      .out_valid_out(out_valid), .out_beat_out(out_beat), .out_ready_in(out_ready));
   imc_source i_src (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .in_ready_in(in_ready),
      .in_valid_out(in_valid), .in_sample_out(in_sample));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic compare(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d,
                      output logic [31:0] r);
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge ref_clk_in); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk_in); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      bus(idx, 1'b0, 32'h0, r);
      compare(r, exp);
      compare(hresp, `IMC_HRESP_OKAY);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      bus(idx, 1'b1, d, r);
   endtask
   task automatic send(input int cnt, input bit chk, input logic [31:0] step);
      imc_note_t t;
      for (int i = 0; i < cnt; i++)
      begin
         rnd = xs(rnd);
         t = '{rnd, c, n.n, chk && (i > 0 || step == 0 || n.chk), step};
         notes.push_back(t);
         i_src.q.push_back(rnd);
      end
      while (notes.size() != 0) @(posedge ref_clk_in);
   endtask
   always @(posedge ref_clk_in)
   begin
      cyc++;
      stall = xs(stall);
      out_ready <= stall[0] | stall[1];
      if (cyc == 20000)
      begin
         num_errors++;
         print_verdict;
      end
   end
   // scoreboard: oldest note against each accepted beat
   always @(posedge ref_clk_in)
      if (!srst_in && out_valid === 1'b1 && out_ready)
      begin
         if (notes.size() == 0)
            compare(1'b1, 1'b0);
         else
         begin
            compare(out_beat.sample, notes[0].s);
            compare(out_beat.cfg, notes[0].c);
            compare(out_beat.beat, bcnt);
            // stage rates: first at n/2 beats, second at n/4 beats, third every beat
            tk = {notes[0].c.third_en, notes[0].c.second_en && (bcnt * 4) % notes[0].n == 0,
                  (bcnt * 2) % notes[0].n == 0};
            compare(out_beat.tick, tk);
            if (bcnt == 0)
            begin
               // phase difference wraps at 32 bits
               dph = out_beat.phase - prevph;
               if (notes[0].chk)
                  compare(dph, notes[0].step);
               prevph = out_beat.phase;
               if (notes[0].c.premod_en)
                  negexp = ~negexp;
            end
            compare(out_beat.premod_neg, negexp);
            bcnt++;
            if (bcnt == notes[0].n)
            begin
               void'(notes.pop_front());
               bcnt = 0;
            end
         end
      end
   initial
   begin
      repeat (8) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      hsel <= 1'b1;
      rd(`IMC_IDX_MODE1, 32'h20);
      rd(`IMC_IDX_MODE3, 32'h0);
      wr(8'h05, 32'hffff_ffff);
      rd(8'h05, 32'h0);
      for (int i = 0; i < 4; i++)
         wr(`IMC_IDX_TW_BASE + 8'(i), tw >> (8 * i));
      c = '{2'h0, 3'h0, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
      n.n = 8;
      n.chk = 1'b1;
      send(3, 1'b1, 32'h0);
      wr(`IMC_IDX_UPDATE, 32'h0);
      wr(`IMC_IDX_UPDATE, 32'h1);
      n.chk = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         if (k == 4)
            wr(`IMC_IDX_TW_BASE, 32'h55);
         m2 = (k % 4 != 0) ? 6'(k * 9) : 6'h0;
         m3 = (k % 4 >= 2) ? ~6'(k * 9) : 6'h0;
         c.first_mode = 2'((k + k / 4) % 4);
         c.second_mode = m2[2:0];
         c.third_mode = m3[2:0];
         c.second_en = (k % 4 != 0);
         c.third_en = (k % 4 >= 2);
         c.second_mod = m2[2];
         c.third_mod = m3[2];
         c.premod_en = (k >= 4) && c.first_mode[0];
         wr(`IMC_IDX_MODE1, {26'h0, 2'(k % 4), 1'b0, k >= 4, c.first_mode});
         wr(`IMC_IDX_MODE2, {26'h0, m2});
         wr(`IMC_IDX_MODE3, {26'h0, m3});
         rd(`IMC_IDX_MODE2, {26'h0, m2});
         n.n = (k % 4 == 3) ? 8 : 2 << (k % 4);
         send(3, 1'b1, tw << 1);
         n.chk = 1'b1;
      end
      rd(`IMC_IDX_TW_BASE, 32'h55);
      rd(`IMC_IDX_UPDATE, 32'h1);
      rd(`IMC_IDX_STATUS, {27'h0, 2'h0, `IMC_FAC_X8, 1'b0});
      print_verdict;
   end
endmodule
